// File: core/spio_cn_detect.v
// Change-notification detector: per-pin previous level compare and sticky request.
// Assumes pin levels are already synchronous to the clock.
`include "spio_defs.vh"
module spio_cn_detect (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Pin levels and enables
	input wire [`SPIO_CN_N-1:0] level_i,
	input wire [`SPIO_CN_N-1:0] enable_i,
	// Clear of the sticky request
	input wire clear_i,
	// Sticky request and per-pin change flags
	output reg req_o,
	output wire [`SPIO_CN_N-1:0] hit_o
);
	reg [`SPIO_CN_N-1:0] prev_r;
	genvar g;
	generate
		for (g = 0; g < `SPIO_CN_N; g = g + 1) begin : g_cn
			// R21: compare with previous
			assign hit_o[g] = enable_i[g] & (level_i[g] ^ prev_r[g]);
		end
	endgenerate
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_r <= {`SPIO_CN_N{1'b0}};
			req_o <= 1'b0;
		end else begin
			prev_r <= level_i;
			// R14: set wins over clear
			if (|hit_o)
				req_o <= 1'b1;
			else if (clear_i)
				req_o <= 1'b0;
		end
	end
endmodule // spio_cn_detect

// File: core/spio_defs.vh
// Constants for the shared-pin I/O port: register indices, widths, reset values.
// Assumes a plain register port with word-wide data and one-cycle strobes.
`ifndef SPIO_DEFS_VH
`define SPIO_DEFS_VH

`define SPIO_W 16
`define SPIO_AW 4
`define SPIO_RP_N 26
`define SPIO_RP_SELW 5
`define SPIO_CN_N 31

// Register indices
`define SPIO_REG_DIR 4'h0
`define SPIO_REG_LEVEL 4'h1
`define SPIO_REG_LATCH 4'h2
`define SPIO_REG_ODC 4'h3
`define SPIO_REG_ANCFG 4'h4
`define SPIO_REG_CNEN_LO 4'h5
`define SPIO_REG_CNEN_HI 4'h6
`define SPIO_REG_PU_LO 4'h7
`define SPIO_REG_PU_HI 4'h8
`define SPIO_REG_CN_STAT 4'h9
`define SPIO_REG_RPSEL 4'hA
`define SPIO_REG_RPIDX 4'hB

// Reset values
`define SPIO_DIR_RST 16'hFFFF
`define SPIO_ANCFG_RST 16'h0000
`define SPIO_ZERO16 16'h0000

// Output-select null code for a remappable pin
`define SPIO_RP_NULL 5'h00

// Which pin bits exist on this variant
`define SPIO_IMPL_MASK 16'hFFFF
// Which pins share an analog channel
`define SPIO_ANALOG_MASK 16'h003F

`endif

// File: core/spio_port.v
// Shared-pin parallel I/O port: direction, latch, readback, open drain, analog,
// change notification, pull-ups and remappable output select.
// Assumes pins and peripheral signals are synchronous to CLOCK_I.
// Summary of operation
// R01: Active peripheral disables port driver, pin readable
// R02: Enabled idle peripheral lets port drive
// R03: Port output never feeds sharing peripheral input; PERIPH_IN_O gets the port drive in the cycle a peripheral starts driving
// R04: Direction bit 1 input, 0 output
// R05: Reset sets every direction bit
// R06: Latch register reads and writes latch
// R07: Level register reads pins, writes latch
// R08: Missing bits disabled and read zero
// R09: Open-drain drives low only
// R10: Analog config resets to all zero
// R11: Analog pins read zero from level
// R12: Software sets analog pins to input
// R13: Software waits a cycle before readback
// R14: Change detect raises interrupt request
// R15: Up to 31 change-notify inputs
// R16: Per-pin change enable over two registers
// R17: Per-pin pull-up over two registers; only the low register drives PULLUP_EN_O
// R18: Software disables pull-up on outputs
// R19: Up to 26 remappable pins selectable
// R20: Null select leaves default port drive
// R21: Compare level with previous, latch difference
`include "spio_defs.vh"
module spio_port (
	// Clock and reset
	input wire CLOCK_I,
	input wire RST_N_I,
	// Register port
	input wire [`SPIO_AW-1:0] ADDR_I,
	input wire [`SPIO_W-1:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [`SPIO_W-1:0] RDATA_O,
	// Pins
	input wire [`SPIO_W-1:0] PIN_I,
	output reg [`SPIO_W-1:0] PIN_O,
	output reg [`SPIO_W-1:0] PIN_OE_O,
	output reg [`SPIO_W-1:0] PULLUP_EN_O,
	// Peripherals sharing the pins
	input wire [`SPIO_W-1:0] PERIPH_EN_I,
	input wire [`SPIO_W-1:0] PERIPH_DRV_I,
	input wire [`SPIO_W-1:0] PERIPH_DATA_I,
	output reg [`SPIO_W-1:0] PERIPH_IN_O,
	// Remappable peripheral outputs, indexed by select code
	input wire [31:0] RP_PERIPH_OUT_I,
	// Change-notification inputs beyond the port pins
	input wire [`SPIO_CN_N-1:0] CN_PIN_I,
	// Change-notification interrupt request
	output reg CN_IRQ_O
);
	reg [`SPIO_W-1:0] pin_direction_r;
	reg [`SPIO_W-1:0] output_latch_r;
	reg [`SPIO_W-1:0] open_drain_select_r;
	reg [`SPIO_W-1:0] analog_pin_config_r;
	reg [`SPIO_W-1:0] change_irq_enable_low_r;
	reg [`SPIO_W-1:0] change_irq_enable_high_r;
	reg [`SPIO_W-1:0] pullup_enable_low_r;
	reg [`SPIO_W-1:0] pullup_enable_high_r;
	reg [`SPIO_RP_SELW-1:0] rp_sel_r [0:`SPIO_RP_N-1];
	reg [`SPIO_RP_SELW-1:0] rp_idx_r;
	reg [`SPIO_W-1:0] rdata_nxt;
	reg [`SPIO_W-1:0] pin_o_nxt;
	reg [`SPIO_W-1:0] pin_oe_nxt;
	reg [`SPIO_W-1:0] level_view;
	wire [`SPIO_CN_N-1:0] cn_enable;
	wire [`SPIO_CN_N-1:0] cn_hit;
	wire cn_req;
	wire cn_clear;
	wire wr_level;
	wire wr_latch;
	wire [`SPIO_W-1:0] analog_pin;
	integer i;
	integer j;

	assign wr_level = WR_I && (ADDR_I == `SPIO_REG_LEVEL);
	assign wr_latch = WR_I && (ADDR_I == `SPIO_REG_LATCH);
	assign cn_clear = WR_I && (ADDR_I == `SPIO_REG_CN_STAT);
	// Analog-capable pins whose config bit still selects analog mode
	assign analog_pin = `SPIO_ANALOG_MASK & ~analog_pin_config_r;
	// R16: enables from two registers
	// R15: 31 change-notify inputs
	assign cn_enable = {change_irq_enable_high_r[`SPIO_CN_N-`SPIO_W-1:0],
		change_irq_enable_low_r};

	// Register writes
	always @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			// R05: all pins input
			pin_direction_r <= `SPIO_DIR_RST;
			output_latch_r <= `SPIO_ZERO16;
			open_drain_select_r <= `SPIO_ZERO16;
			// R10: analog by default
			analog_pin_config_r <= `SPIO_ANCFG_RST;
			change_irq_enable_low_r <= `SPIO_ZERO16;
			change_irq_enable_high_r <= `SPIO_ZERO16;
			pullup_enable_low_r <= `SPIO_ZERO16;
			pullup_enable_high_r <= `SPIO_ZERO16;
			rp_idx_r <= `SPIO_RP_NULL;
			for (i = 0; i < `SPIO_RP_N; i = i + 1)
				rp_sel_r[i] <= `SPIO_RP_NULL;
		end else if (WR_I) begin
			if (ADDR_I == `SPIO_REG_DIR) begin
				pin_direction_r <= WDATA_I & `SPIO_IMPL_MASK;
			// R06: latch write
			// R07: level write goes to latch
			end else if (wr_level || wr_latch) begin
				output_latch_r <= WDATA_I & `SPIO_IMPL_MASK;
			end else if (ADDR_I == `SPIO_REG_ODC) begin
				open_drain_select_r <= WDATA_I & `SPIO_IMPL_MASK;
			end else if (ADDR_I == `SPIO_REG_ANCFG) begin
				analog_pin_config_r <= WDATA_I & `SPIO_ANALOG_MASK;
			end else if (ADDR_I == `SPIO_REG_CNEN_LO) begin
				change_irq_enable_low_r <= WDATA_I;
			end else if (ADDR_I == `SPIO_REG_CNEN_HI) begin
				change_irq_enable_high_r <= {1'b0, WDATA_I[`SPIO_W-2:0]};
			end else if (ADDR_I == `SPIO_REG_PU_LO) begin
				pullup_enable_low_r <= WDATA_I;
			end else if (ADDR_I == `SPIO_REG_PU_HI) begin
				pullup_enable_high_r <= {1'b0, WDATA_I[`SPIO_W-2:0]};
			end else if (ADDR_I == `SPIO_REG_RPIDX) begin
				rp_idx_r <= WDATA_I[`SPIO_RP_SELW-1:0];
			end else if (ADDR_I == `SPIO_REG_RPSEL) begin
				// R19: select per remappable pin
				if (rp_idx_r < `SPIO_RP_N)
					rp_sel_r[rp_idx_r] <= WDATA_I[`SPIO_RP_SELW-1:0];
			end
		end
	end

	// Pin drive and readback views
	always @* begin
		pin_o_nxt = `SPIO_ZERO16;
		pin_oe_nxt = `SPIO_ZERO16;
		level_view = `SPIO_ZERO16;
		for (j = 0; j < `SPIO_W; j = j + 1) begin
			if (PERIPH_EN_I[j] && PERIPH_DRV_I[j]) begin
				// R01: peripheral owns the driver
				pin_o_nxt[j] = PERIPH_DATA_I[j];
				pin_oe_nxt[j] = 1'b1;
			end else if (j < `SPIO_RP_N && rp_sel_r[j] != `SPIO_RP_NULL) begin
				pin_o_nxt[j] = RP_PERIPH_OUT_I[rp_sel_r[j]];
				pin_oe_nxt[j] = ~pin_direction_r[j];
			end else begin
				// R02: port drives when peripheral idle
				// R20: null select keeps port drive
				// R04: direction 0 means output
				pin_o_nxt[j] = output_latch_r[j];
				pin_oe_nxt[j] = ~pin_direction_r[j];
			end
			// R09: open drain drives low only
			if (open_drain_select_r[j]) begin
				pin_oe_nxt[j] = pin_oe_nxt[j] & ~pin_o_nxt[j];
				pin_o_nxt[j] = 1'b0;
			end
			// R11: analog reads zero
			level_view[j] = PIN_I[j] & ~analog_pin[j];
		end
		// R08: missing bits disabled
		pin_o_nxt = pin_o_nxt & `SPIO_IMPL_MASK;
		pin_oe_nxt = pin_oe_nxt & `SPIO_IMPL_MASK;
		level_view = level_view & `SPIO_IMPL_MASK;
	end

	// Read mux
	always @* begin
		rdata_nxt = `SPIO_ZERO16;
		if (ADDR_I == `SPIO_REG_DIR) begin
			rdata_nxt = pin_direction_r;
		end else if (ADDR_I == `SPIO_REG_LEVEL) begin
			// R07: read pin levels
			rdata_nxt = level_view;
		end else if (ADDR_I == `SPIO_REG_LATCH) begin
			// R06: read latch contents
			rdata_nxt = output_latch_r;
		end else if (ADDR_I == `SPIO_REG_ODC) begin
			rdata_nxt = open_drain_select_r;
		end else if (ADDR_I == `SPIO_REG_ANCFG) begin
			rdata_nxt = analog_pin_config_r;
		end else if (ADDR_I == `SPIO_REG_CNEN_LO) begin
			rdata_nxt = change_irq_enable_low_r;
		end else if (ADDR_I == `SPIO_REG_CNEN_HI) begin
			rdata_nxt = change_irq_enable_high_r;
		end else if (ADDR_I == `SPIO_REG_PU_LO) begin
			rdata_nxt = pullup_enable_low_r;
		end else if (ADDR_I == `SPIO_REG_PU_HI) begin
			rdata_nxt = pullup_enable_high_r;
		end else if (ADDR_I == `SPIO_REG_CN_STAT) begin
			rdata_nxt = {{(`SPIO_W-1){1'b0}}, CN_IRQ_O};
		end else if (ADDR_I == `SPIO_REG_RPSEL) begin
			if (rp_idx_r < `SPIO_RP_N)
				rdata_nxt = {{(`SPIO_W-`SPIO_RP_SELW){1'b0}}, rp_sel_r[rp_idx_r]};
		end else if (ADDR_I == `SPIO_REG_RPIDX) begin
			rdata_nxt = {{(`SPIO_W-`SPIO_RP_SELW){1'b0}}, rp_idx_r};
		end
	end

	// Registered outputs
	always @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RDATA_O <= `SPIO_ZERO16;
			PIN_O <= `SPIO_ZERO16;
			PIN_OE_O <= `SPIO_ZERO16;
			PULLUP_EN_O <= `SPIO_ZERO16;
			PERIPH_IN_O <= `SPIO_ZERO16;
			CN_IRQ_O <= 1'b0;
		end else begin
			RDATA_O <= RD_I ? rdata_nxt : `SPIO_ZERO16;
			PIN_O <= pin_o_nxt;
			PIN_OE_O <= pin_oe_nxt;
			// R17: pull-up per pin
			PULLUP_EN_O <= pullup_enable_low_r & `SPIO_IMPL_MASK;
			// R03: port drive masked from peripheral input, except in the cycle a peripheral starts driving
			PERIPH_IN_O <= PIN_I & ~(PIN_OE_O & ~(PERIPH_EN_I & PERIPH_DRV_I));
			// R14: request to processor
			CN_IRQ_O <= cn_req;
		end
	end

	spio_cn_detect u_cn (
		.clk_i(CLOCK_I),
		.rst_n_i(RST_N_I),
		.level_i(CN_PIN_I),
		.enable_i(cn_enable),
		.clear_i(cn_clear),
		.req_o(cn_req),
		.hit_o()
	);
endmodule // spio_port

// File: test/spio_pin_model.sv
// Pin model for the shared-pin port: resolves each pin from port drive, pull-up, board.
// Assumes the board holds a fixed level on every pin that nobody drives.
module spio_pin_model (
	// Port side
	input wire logic [15:0] drive_i,
	input wire logic [15:0] oe_i,
	input wire logic [15:0] pullup_i,
	// Board side
	input wire logic [15:0] ext_i,
	output logic [15:0] pin_o
);
	assign pin_o = (oe_i & drive_i) | (~oe_i & (pullup_i | ext_i));
endmodule // spio_pin_model

// File: test/spio_port_chk.sv
// Checker for the shared-pin port, bound to its top-level ports.
// Assumes one clock domain with an asynchronous active-low reset.
module spio_port_chk (
	// Clock, reset and register port
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic [3:0] ADDR_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [15:0] RDATA_O,
	// Pins and peripherals
	input wire logic [15:0] PIN_OE_O,
	input wire logic [15:0] PULLUP_EN_O,
	input wire logic [15:0] PERIPH_EN_I,
	input wire logic [15:0] PERIPH_DRV_I,
	input wire logic [15:0] PERIPH_IN_O,
	// Change notification
	input wire logic [30:0] CN_PIN_I,
	input wire logic CN_IRQ_O
);
	logic clr_d;
	wire clr_w = WR_I && ADDR_I == 4'h9;
	wire [31:0] per_w = {PERIPH_EN_I, PERIPH_DRV_I};
	// Status clear seen one cycle late
	always @(posedge CLOCK_I) clr_d <= clr_w;
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_N_I);
	AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
		else $error("read data outside a read cycle");
	AST_RD_UNMAPPED: assert property ($past(RD_I) && $past(ADDR_I) > 4'hB |-> !RDATA_O)
		else $error("unmapped read not zero");
	AST_RST_OUT: assert property ($rose(RST_N_I) |-> PIN_OE_O == 16'h0000 && !CN_IRQ_O)
		else $error("port drives right after reset");
	AST_OE_CAUSE: assert property ($changed(PIN_OE_O) |-> $past(WR_I) || $past(WR_I, 2)
		|| $past(per_w) != $past(per_w, 2) || $past(per_w, 2) != $past(per_w, 3))
		else $error("drive enable changed without cause");
	AST_PU_CAUSE: assert property ($changed(PULLUP_EN_O) |-> $past(WR_I) || $past(WR_I, 2))
		else $error("pull-up changed without a write");
	AST_LOOP: assert property (!PERIPH_EN_I && !$past(PERIPH_EN_I)
		|-> (PERIPH_IN_O & PIN_OE_O & $past(PIN_OE_O)) == 16'h0000)
		else $error("port output loops into peripheral input");
	AST_CN_HOLD: assert property (CN_IRQ_O && !clr_w && !clr_d |=> CN_IRQ_O)
		else $error("change request dropped without clear");
	AST_CN_CAUSE: assert property ($rose(CN_IRQ_O) |-> $past(CN_PIN_I) != $past(CN_PIN_I, 2)
		|| $past(CN_PIN_I, 2) != $past(CN_PIN_I, 3))
		else $error("change request without a change");
endmodule // spio_port_chk
bind spio_port spio_port_chk i_spio_port_chk (.CLOCK_I, .RST_N_I, .ADDR_I, .WR_I, .RD_I,
	.RDATA_O, .PIN_OE_O, .PULLUP_EN_O, .PERIPH_EN_I, .PERIPH_DRV_I, .PERIPH_IN_O,
	.CN_PIN_I, .CN_IRQ_O);

// File: test/spio_port_tb.sv
// Bench for the shared-pin port: register tasks and pin scenarios.
// Assumes the pin model closes the loop from port outputs to PIN_I.
`include "spio_defs.vh"
module spio_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [15:0] wd = 16'h0000, pen = 16'h0000, pdrv = 16'h0000, pdat = 16'h0002;
	logic [15:0] ext = 16'hA53F;
	logic [31:0] rpo = 32'hFFFFFFFE;
	logic [30:0] cn = 31'h00000000;
	wire [15:0] rdat, pin, po, oe, pu, pin_per;
	wire irq;
	int err_count = 0, n_compared = 0, n;
	spio_port i_spio_port (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(adr), .WDATA_I(wd),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .PIN_I(pin), .PIN_O(po), .PIN_OE_O(oe),
		.PULLUP_EN_O(pu), .PERIPH_EN_I(pen), .PERIPH_DRV_I(pdrv), .PERIPH_DATA_I(pdat),
		.PERIPH_IN_O(pin_per), .RP_PERIPH_OUT_I(rpo), .CN_PIN_I(cn), .CN_IRQ_O(irq));
	spio_pin_model i_spio_pin_model (.drive_i(po), .oe_i(oe), .pullup_i(pu), .ext_i(ext),
		.pin_o(pin));
	initial begin
		forever #20 clk = ~clk;
	end
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %0t saw %h expected %h", $time, s, e);
		end
	endtask
	task wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		adr <= a;
		wd <= d;
		// hold the write strobe for one clock edge
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		adr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdat, e);
	endtask
	task settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task wait_irq;
		for (n = 0; n < 8 && irq !== 1'b1; n++) @(posedge clk);
		#1;
		chk({15'h0000, irq}, 16'h0001);
		if (irq !== 1'b1) test_done;
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task t_reset;
		rreg(`SPIO_REG_DIR, 16'hFFFF);
		rreg(`SPIO_REG_ANCFG, 16'h0000);
		rreg(`SPIO_REG_LEVEL, 16'hA500);
		rreg(4'hF, 16'h0000);
		chk(oe, 16'h0000);
	endtask
	task t_port;
		// analog pins stay inputs until made digital
		wreg(`SPIO_REG_ANCFG, 16'hFFFF);
		wreg(`SPIO_REG_DIR, 16'hFF00);
		wreg(`SPIO_REG_LATCH, 16'h1234);
		rreg(`SPIO_REG_LATCH, 16'h1234);
		rreg(`SPIO_REG_LEVEL, 16'hA534);
		chk(oe, 16'h00FF);
		chk(pin_per, 16'hA500);
		wreg(`SPIO_REG_LEVEL, 16'h0055);
		rreg(`SPIO_REG_LATCH, 16'h0055);
		wreg(`SPIO_REG_ODC, 16'h0003);
		settle;
		chk(oe, 16'h00FE);
		chk(pin & 16'h0003, 16'h0001);
		wreg(`SPIO_REG_ODC, 16'h0000);
	endtask
	task t_share;
		@(posedge clk);
		pen <= 16'h0002;
		pdrv <= 16'h0002;
		settle;
		rreg(`SPIO_REG_LEVEL, 16'hA557);
		pdrv <= 16'h0000;
		settle;
		chk(pin & 16'h0002, 16'h0000);
		pen <= 16'h0000;
		wreg(`SPIO_REG_RPIDX, 16'h0003);
		wreg(`SPIO_REG_RPSEL, 16'h0000);
		settle;
		chk(pin & 16'h0008, 16'h0000);
		wreg(`SPIO_REG_RPSEL, 16'h0003);
		settle;
		chk(pin & 16'h0008, 16'h0008);
	endtask
	task t_cn;
		// pull-up only on an input pin
		wreg(`SPIO_REG_PU_LO, 16'h4000);
		rreg(`SPIO_REG_LEVEL, 16'hE55D);
		wreg(`SPIO_REG_CNEN_LO, 16'h0001);
		wreg(`SPIO_REG_CNEN_HI, 16'h4000);
		cn <= 31'h00000002;
		settle;
		chk({15'h0000, irq}, 16'h0000);
		cn <= 31'h00000003;
		wait_irq;
		rreg(`SPIO_REG_CN_STAT, 16'h0001);
		wreg(`SPIO_REG_CN_STAT, 16'h0000);
		settle;
		chk({15'h0000, irq}, 16'h0000);
		cn <= 31'h40000003;
		wait_irq;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_port;
		t_share;
		t_cn;
		test_done;
	end
endmodule // spio_port_tb
